// File: rtl/monitor_results_pkg.sv
package monitor_results_pkg;

	// Clock and PWM timing
	localparam int CLK_HZ       = 40_000_000;   // Core clock rate
	localparam int PWM_FREQ_HZ  = 1000;         // Target PWM repetition rate
	localparam int PWM_STEPS    = 512;          // Nine-bit PWM resolution
	localparam int PWM_PRESCALE = CLK_HZ / (PWM_STEPS * PWM_FREQ_HZ); // Clocks per step

	// Register offsets on the serial interface
	localparam logic [4:0] REG_STATUS_LO = 5'h00; // Freshness of inputs one to eight
	localparam logic [4:0] REG_STATUS_HI = 5'h01; // Enables plus internal/supply freshness
	localparam logic [4:0] REG_CTRL_A    = 5'h06; // Pairs one/two and three/four
	localparam logic [4:0] REG_CTRL_B    = 5'h07; // Pairs five/six and seven/eight
	localparam logic [4:0] REG_PWM_CFG   = 5'h08; // PWM control, internal temp control
	localparam logic [4:0] REG_PWM_THR   = 5'h09; // Threshold upper eight bits
	localparam logic [4:0] REG_RES_BASE  = 5'h0a; // First result upper byte
	localparam logic [4:0] REG_LAST      = 5'h1d; // Pointer wraps after this one

	// Field positions inside a pair nibble of the channel control registers
	localparam int PAIR_TEMP_BIT   = 1; // Pair measures a remote diode
	localparam int PAIR_KELVIN_BIT = 2; // Kelvin scale for the pair
	localparam int PAIR_FILTER_BIT = 3; // Filter enable for the pair

	// Field positions inside the PWM configuration register
	localparam int CFG_INT_KELVIN = 2; // Kelvin scale for internal sensor
	localparam int CFG_INT_FILTER = 3; // Filter enable for internal sensor
	localparam int CFG_PWM_INVERT = 5; // Invert PWM polarity
	localparam int CFG_PWM_ENABLE = 6; // Enable PWM output
	localparam int CFG_THR_LSB    = 7; // Threshold bit zero

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00; // All control registers
	localparam logic [6:0] ADDR_RESET = 7'h48; // Default slave address

	// Result slots
	localparam int RES_COUNT = 10;            // Eight inputs, internal temp, supply
	localparam logic [3:0] RES_INT_TEMP = 4'h8; // Internal temperature slot
	localparam logic [3:0] RES_SUPPLY   = 4'h9; // Supply voltage slot
	localparam logic [3:0] RES_CH7      = 4'h6; // seventh_input_channel slot

	// PWM span above threshold in result codes
	localparam logic signed [14:0] PWM_SPAN = 15'sh0200;

	// One conversion handed over by the sequencer
	typedef struct packed {
		logic [3:0]  chan; // Result slot 0..9
		logic [13:0] code; // Raw two's complement code
	} sample_t;

	// Serial states
	typedef enum logic [3:0] {
		SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_CMD, SER_CMD_ACK,
		SER_WDATA, SER_WDATA_ACK, SER_RDATA, SER_RDATA_ACK, SER_WAIT
	} ser_state_t;

endpackage : monitor_results_pkg

// File: rtl/monitor_results_pwm_i2c.sv
`timescale 1ns/1ps

module monitor_results_pwm_i2c #(
	parameter logic [6:0] SLAVE_ADDR = monitor_results_pkg::ADDR_RESET,  // Bus address
	parameter int         STEP_CLKS  = monitor_results_pkg::PWM_PRESCALE // Clocks per PWM step
) (
	input  wire logic                          core_clk,
	input  wire logic                          srst,
	input  wire logic                          sclIn,
	input  wire logic                          sdaIn,
	output logic                               sdaOut,
	output logic                               sdaOeN,
	input  wire logic                          sampleValid,
	input  wire monitor_results_pkg::sample_t  sample,
	output logic                               sampleReady,
	output logic                               pwmOut
);

	// Pin synchronisers, stage one read only by stage two
	logic [1:0] sclSync_q;    // SCL synchroniser
	logic [1:0] sdaSync_q;    // SDA synchroniser
	logic       sclPrev_q;    // Delayed SCL for edges
	logic       sdaPrev_q;    // Delayed SDA for edges

	// Serial engine state
	monitor_results_pkg::ser_state_t serState_q; // Protocol state
	logic [7:0] rxShift_q;    // Incoming byte
	logic [7:0] txShift_q;    // Outgoing byte
	logic [2:0] bitCnt_q;     // Bits seen in this byte
	logic       byteDone_q;   // Eighth bit sampled
	logic       masterAck_q;  // Master acked last read byte
	logic [4:0] ptr_q;        // Register pointer
	logic       readBusy_q;   // Read transfer in progress
	logic       sdaOeN_q;     // Open-drain enable, low pulls SDA
	logic       sdaOut_q;     // Driven level, always low

	// Register file
	logic [7:0] ctrlA_q;      // Pairs one/two and three/four
	logic [7:0] ctrlB_q;      // Pairs five/six and seven/eight
	logic [7:0] pwmCfg_q;     // pwm_cfg_internal_temp_ctrl
	logic [7:0] thrUpper_q;   // pwm_threshold_upper
	logic [7:2] statHiCfg_q;  // Writable upper bits of status high

	// Result store and freshness
	logic [13:0] resData_q [monitor_results_pkg::RES_COUNT]; // Result codes
	logic [monitor_results_pkg::RES_COUNT-1:0] fresh_q;      // Freshness flags
	logic        clrReq_q;    // Addressed-result clear request
	logic [3:0]  clrIdx_q;    // Slot to clear
	logic        sampleReady_q; // Sequencer may hand over

	// PWM
	localparam int PRE_W = $clog2(STEP_CLKS);
	logic [PRE_W-1:0] preCnt_q; // Step prescaler
	logic [8:0] pwmCnt_q;       // 512-step ramp
	logic       pwmOut_q;       // Registered PWM pin

	// Bus conditions
	wire sclS      = sclSync_q[1];
	wire sdaS      = sdaSync_q[1];
	wire sclRise   = sclS & ~sclPrev_q;
	wire sclFall   = ~sclS & sclPrev_q;
	wire startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
	wire stopCond  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

	// Per-pair control decode
	logic [3:0] pairTemp;   // Pair in diode mode
	logic [3:0] pairKelvin; // Pair in Kelvin scale
	logic [3:0] pairFilter; // Pair filter enabled
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_pair
			// Even pairs in low nibble, odd pairs in high nibble
			wire [7:0] cb = (gp < 2) ? ctrlA_q : ctrlB_q;
			wire [3:0] nb = (gp % 2 == 1) ? cb[7:4] : cb[3:0];
			assign pairTemp[gp]   = nb[monitor_results_pkg::PAIR_TEMP_BIT];
			assign pairKelvin[gp] = nb[monitor_results_pkg::PAIR_KELVIN_BIT];
			assign pairFilter[gp] = nb[monitor_results_pkg::PAIR_FILTER_BIT];
		end
	endgenerate

	// Temperature layout per slot: first of a diode pair, or internal sensor
	logic [monitor_results_pkg::RES_COUNT-1:0] tempFmt;
	genvar gr;
	generate
		for (gr = 0; gr < monitor_results_pkg::RES_COUNT; gr++) begin : g_fmt
			if (gr == 8) begin : g_int
				assign tempFmt[gr] = 1'b1;
			end else if (gr == 9) begin : g_sup
				assign tempFmt[gr] = 1'b0;
			end else begin : g_in
				// Second of a diode pair stays voltage layout (diode volts)
				assign tempFmt[gr] = (gr % 2 == 0) & pairTemp[gr/2];
			end
		end
	endgenerate

	// Incoming sample decode
	wire [3:0]  sIdx     = sample.chan;
	wire        sInRange = sIdx < 4'(monitor_results_pkg::RES_COUNT);
	wire [1:0]  sPair    = sIdx[2:1];
	wire        sIsInt   = sIdx == monitor_results_pkg::RES_INT_TEMP;
	wire        sIsTemp  = sInRange & tempFmt[sIdx];
	wire        sKelvin  = sIsInt ? pwmCfg_q[monitor_results_pkg::CFG_INT_KELVIN]
	                              : pairKelvin[sPair];
	// Supply slot is never filtered
	wire        sFilter  = (sIdx == monitor_results_pkg::RES_SUPPLY) ? 1'b0 :
	                       sIsInt ? pwmCfg_q[monitor_results_pkg::CFG_INT_FILTER] :
	                       pairFilter[sPair];

	// Thirteen-bit temperature sign-extended into the common store
	wire [13:0] sTemp    = {sample.code[12], sample.code[12:0]};
	wire [13:0] sRaw     = sIsTemp ? ((sKelvin & sample.code[12]) ? 14'h0000 : sTemp)
	                               : sample.code;
	// Prior value is whatever is stored, filtered or not
	wire [13:0] sOld     = sInRange ? resData_q[sIdx] : 14'h0000;
	wire signed [17:0] oldExt = {{4{sOld[13]}}, sOld};
	wire signed [17:0] newExt = {{4{sRaw[13]}}, sRaw};
	wire signed [17:0] filtSum = (oldExt <<< 4) - oldExt + newExt;
	wire signed [17:0] filtQ   = filtSum >>> 4;
	wire [13:0] sStore   = sFilter ? filtQ[13:0] : sRaw;
	// Hold off the sequencer while a read is being served
	wire        accept   = sampleValid & sampleReady_q & ~readBusy_q & sInRange;

	// Read data selection
	wire [4:0]  ptrOff   = ptr_q - monitor_results_pkg::REG_RES_BASE;
	wire        ptrIsRes = (ptr_q >= monitor_results_pkg::REG_RES_BASE) &
	                       (ptr_q <= monitor_results_pkg::REG_LAST);
	wire [3:0]  rIdx     = ptrIsRes ? ptrOff[4:1] : 4'h0;
	wire [13:0] rData    = resData_q[rIdx];
	wire [7:0]  rUpper   = tempFmt[rIdx] ? {fresh_q[rIdx], 2'b00, rData[12:8]}
	                                     : {fresh_q[rIdx], rData[13], rData[13:8]};
	wire [7:0]  rResult  = ptrOff[0] ? rData[7:0] : rUpper;
	wire [7:0]  statLo   = fresh_q[7:0];
	wire [7:0]  statHi   = {statHiCfg_q, fresh_q[8], fresh_q[9]};
	wire [7:0]  rdByte   =
		ptrIsRes                                   ? rResult    :
		(ptr_q == monitor_results_pkg::REG_STATUS_LO) ? statLo     :
		(ptr_q == monitor_results_pkg::REG_STATUS_HI) ? statHi     :
		(ptr_q == monitor_results_pkg::REG_CTRL_A)    ? ctrlA_q    :
		(ptr_q == monitor_results_pkg::REG_CTRL_B)    ? ctrlB_q    :
		(ptr_q == monitor_results_pkg::REG_PWM_CFG)   ? pwmCfg_q   :
		(ptr_q == monitor_results_pkg::REG_PWM_THR)   ? thrUpper_q : 8'h00;
	wire [4:0]  ptrNext  = (ptr_q == monitor_results_pkg::REG_LAST) ? 5'h00
	                                                                 : ptr_q + 5'h01;
	// Register addressed by a freshly latched command byte
	wire [4:0]  cmdPtr   = rxShift_q[4:0];

	// Pin synchronisers and edge history
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sclSync_q <= 2'h3;
			sdaSync_q <= 2'h3;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclSync_q <= {sclSync_q[0], sclIn};
			sdaSync_q <= {sdaSync_q[0], sdaIn};
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	// Serial slave engine and register writes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			serState_q  <= monitor_results_pkg::SER_IDLE;
			rxShift_q   <= 8'h00;
			txShift_q   <= 8'h00;
			bitCnt_q    <= 3'h0;
			byteDone_q  <= 1'b0;
			masterAck_q <= 1'b0;
			ptr_q       <= 5'h00;
			readBusy_q  <= 1'b0;
			sdaOeN_q    <= 1'b1;
			clrReq_q    <= 1'b0;
			clrIdx_q    <= 4'h0;
			ctrlA_q     <= monitor_results_pkg::CTRL_RESET;
			ctrlB_q     <= monitor_results_pkg::CTRL_RESET;
			pwmCfg_q    <= monitor_results_pkg::CTRL_RESET;
			thrUpper_q  <= monitor_results_pkg::CTRL_RESET;
			statHiCfg_q <= 6'h00;
		end else begin
			clrReq_q <= 1'b0;
			if (startCond) begin
				// Repeated start restarts address phase exactly like start
				serState_q <= monitor_results_pkg::SER_ADDR;
				bitCnt_q   <= 3'h0;
				byteDone_q <= 1'b0;
				sdaOeN_q   <= 1'b1;
				readBusy_q <= 1'b0;
			end else if (stopCond) begin
				serState_q <= monitor_results_pkg::SER_IDLE;
				sdaOeN_q   <= 1'b1;
				readBusy_q <= 1'b0;
			end else if (sclRise) begin
				// Sample receiving bits, count all data bits
				rxShift_q <= {rxShift_q[6:0], sdaS};
				bitCnt_q  <= bitCnt_q + 3'h1;
				if (bitCnt_q == 3'h7) begin
					byteDone_q <= 1'b1;
				end
				if (serState_q == monitor_results_pkg::SER_RDATA_ACK) begin
					masterAck_q <= ~sdaS;
				end
			end else if (sclFall) begin
				unique case (serState_q)
					monitor_results_pkg::SER_ADDR: begin
						if (byteDone_q) begin
							byteDone_q <= 1'b0;
							if (rxShift_q[7:1] == SLAVE_ADDR) begin
								sdaOeN_q   <= 1'b0;
								serState_q <= monitor_results_pkg::SER_ADDR_ACK;
							end else begin
								serState_q <= monitor_results_pkg::SER_WAIT;
							end
						end
					end
					monitor_results_pkg::SER_ADDR_ACK: begin
						bitCnt_q <= 3'h0;
						// Ack bit has shifted in behind the R/W bit
						if (rxShift_q[1]) begin
							// Read: first bit goes out now, pointer moves on
							txShift_q  <= {rdByte[6:0], 1'b0};
							sdaOeN_q   <= rdByte[7];
							ptr_q      <= ptrNext;
							readBusy_q <= 1'b1;
							clrReq_q   <= ptrIsRes;
							clrIdx_q   <= rIdx;
							serState_q <= monitor_results_pkg::SER_RDATA;
						end else begin
							sdaOeN_q   <= 1'b1;
							serState_q <= monitor_results_pkg::SER_CMD;
						end
					end
					monitor_results_pkg::SER_CMD: begin
						if (byteDone_q) begin
							byteDone_q <= 1'b0;
							ptr_q      <= cmdPtr;
							sdaOeN_q   <= 1'b0;
							serState_q <= monitor_results_pkg::SER_CMD_ACK;
						end
					end
					monitor_results_pkg::SER_CMD_ACK,
					monitor_results_pkg::SER_WDATA_ACK: begin
						bitCnt_q   <= 3'h0;
						sdaOeN_q   <= 1'b1;
						serState_q <= monitor_results_pkg::SER_WDATA;
					end
					monitor_results_pkg::SER_WDATA: begin
						if (byteDone_q) begin
							// Word writes land in the next register in turn
							byteDone_q <= 1'b0;
							sdaOeN_q   <= 1'b0;
							ptr_q      <= ptrNext;
							serState_q <= monitor_results_pkg::SER_WDATA_ACK;
							unique case (ptr_q)
								monitor_results_pkg::REG_STATUS_HI: statHiCfg_q <= rxShift_q[7:2];
								monitor_results_pkg::REG_CTRL_A:    ctrlA_q     <= rxShift_q;
								monitor_results_pkg::REG_CTRL_B:    ctrlB_q     <= rxShift_q;
								monitor_results_pkg::REG_PWM_CFG:   pwmCfg_q    <= rxShift_q;
								monitor_results_pkg::REG_PWM_THR:   thrUpper_q  <= rxShift_q;
								default: ;
							endcase
						end
					end
					monitor_results_pkg::SER_RDATA: begin
						if (byteDone_q) begin
							// Release for the master's acknowledge
							byteDone_q <= 1'b0;
							sdaOeN_q   <= 1'b1;
							serState_q <= monitor_results_pkg::SER_RDATA_ACK;
						end else begin
							txShift_q <= {txShift_q[6:0], 1'b0};
							sdaOeN_q  <= txShift_q[7];
						end
					end
					monitor_results_pkg::SER_RDATA_ACK: begin
						bitCnt_q <= 3'h0;
						if (masterAck_q) begin
							txShift_q  <= {rdByte[6:0], 1'b0};
							sdaOeN_q   <= rdByte[7];
							ptr_q      <= ptrNext;
							clrReq_q   <= ptrIsRes;
							clrIdx_q   <= rIdx;
							serState_q <= monitor_results_pkg::SER_RDATA;
						end else begin
							// Not acknowledged: read ends, sequencer resumes
							readBusy_q <= 1'b0;
							serState_q <= monitor_results_pkg::SER_WAIT;
						end
					end
					monitor_results_pkg::SER_IDLE,
					monitor_results_pkg::SER_WAIT: ;
				endcase
			end
		end
	end

	// Result store: both bytes of a result change in the same edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < monitor_results_pkg::RES_COUNT; i++) begin
				resData_q[i] <= 14'h0000;
			end
		end else if (accept) begin
			resData_q[sIdx] <= sStore;
		end
	end

	// Freshness flags; a new result beats a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fresh_q <= '0;
		end else begin
			for (int i = 0; i < monitor_results_pkg::RES_COUNT; i++) begin
				if (accept && sIdx == 4'(i)) begin
					fresh_q[i] <= 1'b1;
				end else if (clrReq_q && clrIdx_q == 4'(i)) begin
					fresh_q[i] <= 1'b0;
				end
			end
		end
	end

	// Sequencer handshake, low through any read
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sampleReady_q <= 1'b0;
		end else begin
			sampleReady_q <= ~readBusy_q;
		end
	end

	// PWM transfer: stored channel seven is already filtered when enabled
	wire [12:0] ch7Code = resData_q[monitor_results_pkg::RES_CH7][12:0];
	wire        ch7Kel  = pairKelvin[3];
	wire [8:0]  thr9    = {thrUpper_q, pwmCfg_q[monitor_results_pkg::CFG_THR_LSB]};
	wire signed [14:0] tempExt = ch7Kel ? {2'b00, ch7Code}
	                                    : {{2{ch7Code[12]}}, ch7Code};
	wire signed [14:0] thrExt  = ch7Kel ? {2'b00, thr9, 4'h0}
	                                    : {{2{thr9[8]}}, thr9, 4'h0};
	wire signed [14:0] diff    = tempExt - thrExt;
	wire        dutyZero = diff < 15'sh0000;
	wire        dutyFull = diff >= monitor_results_pkg::PWM_SPAN;
	wire        pwmLevel = dutyFull | (~dutyZero & (pwmCnt_q < diff[8:0]));
	wire        preWrap  = preCnt_q == PRE_W'(STEP_CLKS - 1);

	// Prescaler and 512-step ramp, about 1 kHz period
	always_ff @(posedge core_clk) begin
		if (srst) begin
			preCnt_q <= '0;
			pwmCnt_q <= 9'h000;
		end else begin
			preCnt_q <= preWrap ? '0 : preCnt_q + PRE_W'(1);
			if (preWrap) begin
				pwmCnt_q <= pwmCnt_q + 9'h001;
			end
		end
	end

	// Output stage: disabled holds low, invert flips the level at every duty, not only the flat regions
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pwmOut_q <= 1'b0;
		end else begin
			pwmOut_q <= pwmCfg_q[monitor_results_pkg::CFG_PWM_ENABLE] &
			            (pwmLevel ^ pwmCfg_q[monitor_results_pkg::CFG_PWM_INVERT]);
		end
	end

	// Never drive SDA high; only the enable moves
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sdaOut_q <= 1'b0;
		end else begin
			sdaOut_q <= 1'b0;
		end
	end

	assign sdaOut      = sdaOut_q;
	assign sdaOeN      = sdaOeN_q;
	assign sampleReady = sampleReady_q;
	assign pwmOut      = pwmOut_q;

endmodule : monitor_results_pwm_i2c

// File: tb/monitor_results_chk.sv
`timescale 1ns/1ps
module monitor_results_chk (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOeN,
	input wire logic sampleReady,
	input wire logic pwmOut
);
	logic [7:0] idleCnt_q; // Cycles with both bus lines high

	// Saturating idle count, longer than any bit half
	always_ff @(posedge core_clk) begin
		if (srst || !(sclIn && sdaIn)) begin
			idleCnt_q <= 8'h00;
		end else if (idleCnt_q != 8'hff) begin
			idleCnt_q <= idleCnt_q + 8'h01;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	property p_sdaNeverHigh;
		sdaOut == 1'b0;
	endproperty
	a_sdaNeverHigh: assert property (p_sdaNeverHigh)
		else $error("SDA driven high");
	property p_resetRelease;
		$fell(srst) |-> (sdaOeN && !sampleReady && !pwmOut) ##1 sampleReady;
	endproperty
	a_resetRelease: assert property (p_resetRelease)
		else $error("outputs wrong around reset release");
	// SDA may only move shortly after an SCL fall, never while SCL is high
	property p_sdaAfterFall;
		$changed(sdaOeN) |-> !$past(sclIn, 2) && ($past(sclIn, 3) || $past(sclIn, 4)
			|| $past(sclIn, 5) || $past(sclIn, 6));
	endproperty
	a_sdaAfterFall: assert property (p_sdaAfterFall)
		else $error("SDA moved away from an SCL fall");
	property p_oeHolds;
		$changed(sdaOeN) |=> $stable(sdaOeN) [*8];
	endproperty
	a_oeHolds: assert property (p_oeHolds)
		else $error("SDA drive glitched");
	property p_readyFallsLow;
		$fell(sampleReady) |-> !$past(sclIn, 2) && !sclIn;
	endproperty
	a_readyFallsLow: assert property (p_readyFallsLow)
		else $error("sampleReady fell outside a read start");
	property p_stopFrees;
		sclIn && $rose(sdaIn) |-> ##[1:10] sampleReady;
	endproperty
	a_stopFrees: assert property (p_stopFrees)
		else $error("sampleReady not back after stop");
	property p_startReleased;
		sclIn && $fell(sdaIn) |-> sdaOeN [*8];
	endproperty
	a_startReleased: assert property (p_startReleased)
		else $error("SDA pulled during start");
	property p_idleReady;
		idleCnt_q == 8'h64 |-> sampleReady && sdaOeN;
	endproperty
	a_idleReady: assert property (p_idleReady)
		else $error("idle bus but results frozen");
endmodule : monitor_results_chk

bind monitor_results_pwm_i2c monitor_results_chk i_monitor_results_chk (
	.core_clk(core_clk), .srst(srst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOeN(sdaOeN), .sampleReady(sampleReady), .pwmOut(pwmOut));

// File: tb/i2c_host.sv
`timescale 1ns/1ps
module i2c_host (
	input  wire logic core_clk,
	input  wire logic sdaWire,
	output logic      sclPin,
	output logic      sdaRel
);
	// Quarter bit in clocks; 2.5 us bits keep the bus at 400 kbit/s
	localparam int QTR = 25;

	// Both lines released: idle bus
	initial begin
		sclPin = 1'b1;
		sdaRel = 1'b1;
	end

	task automatic q();
		repeat (QTR) @(negedge core_clk);
	endtask : q

	// One bit; data set while SCL low, sampled mid-high
	task automatic bitIo(input logic b, output logic r);
		sdaRel = b;
		q();
		sclPin = 1'b1;
		q();
		r = sdaWire;
		q();
		sclPin = 1'b0;
		q();
	endtask : bitIo

	// Start or repeated start: SDA falls with SCL high
	task automatic sendStart();
		sdaRel = 1'b1;
		q();
		sclPin = 1'b1;
		q();
		sdaRel = 1'b0;
		q();
		sclPin = 1'b0;
		q();
	endtask : sendStart

	// Stop: SDA rises with SCL high, then both stand still
	task automatic sendStop();
		sdaRel = 1'b0;
		q();
		sclPin = 1'b1;
		q();
		sdaRel = 1'b1;
		q();
	endtask : sendStop

	task automatic putByte(input logic [7:0] d, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitIo(d[i], r);
		end
		bitIo(1'b1, nack);
	endtask : putByte

	// Last byte answered with a high bit to end the read
	task automatic getByte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitIo(1'b1, d[i]);
		end
		bitIo(last, r);
	endtask : getByte
endmodule : i2c_host

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
	localparam logic [6:0] DEV = monitor_results_pkg::ADDR_RESET; // Design bus address
	localparam int         STEP = 4; // Short PWM step keeps the run brief
	localparam logic [3:0] CH7 = monitor_results_pkg::RES_CH7;
	localparam logic [3:0] SUP = monitor_results_pkg::RES_SUPPLY;
	logic                         core_clk = 1'b0;
	logic                         srst = 1'b1;
	logic                         sampleValid = 1'b0;
	monitor_results_pkg::sample_t sample = 18'h00000;
	logic                         sclPin, sdaRel, sdaOut, sdaOeN, sampleReady, pwmOut;
	wire                          sdaWire = sdaRel & (sdaOeN | sdaOut); // Pulled up
	int                           nFail = 0;
	int                           numChecks = 0;

	always #12.5 core_clk = ~core_clk;

	i2c_host i_i2c_host (.core_clk(core_clk), .sdaWire(sdaWire), .sclPin(sclPin),
		.sdaRel(sdaRel));
	monitor_results_pwm_i2c #(.STEP_CLKS(STEP)) i_monitor_results_pwm_i2c (
		.core_clk(core_clk), .srst(srst),
		.sclIn(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.sampleValid(sampleValid), .sample(sample), .sampleReady(sampleReady),
		.pwmOut(pwmOut));

	task automatic summarize();
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		numChecks++;
		if (g !== e) begin
			nFail++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// Start, address for writing, command byte
	task automatic head(logic [4:0] r, output logic [1:0] nk);
		i_i2c_host.sendStart();
		i_i2c_host.putByte({DEV, 1'b0}, nk[1]);
		i_i2c_host.putByte({3'h0, r}, nk[0]);
	endtask : head

	task automatic wr(logic [4:0] r, logic [15:0] d, bit two);
		logic [1:0] nk;
		logic       n1, n2;
		head(r, nk);
		n1 = 1'b0;
		if (two) i_i2c_host.putByte(d[15:8], n1);
		i_i2c_host.putByte(d[7:0], n2);
		i_i2c_host.sendStop();
		chk("write ack", 16'h0000, {12'h000, nk, n1, n2});
	endtask : wr

	// Byte or word read through a repeated start, compared with e
	task automatic rc(string n, logic [4:0] r, bit two, logic [15:0] e);
		logic [1:0]  nk;
		logic        na;
		logic [15:0] d;
		head(r, nk);
		i_i2c_host.sendStart();
		i_i2c_host.putByte({DEV, 1'b1}, na);
		d = 16'h0000;
		if (two) i_i2c_host.getByte(1'b0, d[15:8]);
		i_i2c_host.getByte(1'b1, d[7:0]);
		i_i2c_host.sendStop();
		chk("read ack", 16'h0000, {13'h0000, nk, na});
		chk(n, e, d);
	endtask : rc

	// Offer a result and hold it until taken
	task automatic push(logic [3:0] ch, logic [13:0] code);
		sampleValid = 1'b1;
		sample = {ch, code};
		for (int k = 0; k < 2000 && sampleReady !== 1'b1; k++) @(negedge core_clk);
		chk("push ready", 16'h0001, {15'h0000, sampleReady});
		@(negedge core_clk);
		sampleValid = 1'b0;
	endtask : push

	// High clocks of pwmOut over a window, after the level settles
	task automatic pwmChk(string n, int w, int e);
		int h;
		h = 0;
		repeat (200) @(negedge core_clk);
		repeat (w) begin
			@(negedge core_clk);
			if (pwmOut === 1'b1) h++;
		end
		chk(n, e[15:0], h[15:0]);
	endtask : pwmChk

	task automatic t_regs();
		logic na;
		rc("ctrl reset", 5'h08, 1, 16'h0000);
		wr(5'h06, 16'h1120, 1);
		rc("ctrl word", 5'h06, 1, 16'h1120);
		wr(5'h00, 16'h00ff, 0);
		rc("reserved", 5'h03, 0, 16'h0000);
		i_i2c_host.sendStart();
		i_i2c_host.putByte({DEV ^ 7'h01, 1'b0}, na);
		i_i2c_host.sendStop();
		chk("foreign nack", 16'h0001, {15'h0000, na});
	endtask : t_regs

	task automatic t_temp();
		push(CH7, 14'h1fff);
		rc("status", 5'h00, 0, 16'h0040);
		rc("temp neg", 5'h16, 1, 16'h9fff);
		rc("temp stale", 5'h16, 1, 16'h1fff);
		wr(5'h07, 16'h0060, 0);
		push(CH7, 14'h1ff0);
		rc("kelvin", 5'h16, 1, 16'h8000);
	endtask : t_temp

	task automatic t_volt();
		push(4'h0, 14'h2abc);
		push(SUP, 14'h0123);
		rc("volt neg", 5'h0a, 1, 16'heabc);
		rc("supply", 5'h1c, 1, 16'h8123);
		rc("wrap", 5'h1d, 1, 16'h2300);
	endtask : t_volt

	// Seed unfiltered, then filter on; internal filter must not touch supply
	task automatic t_filt();
		wr(5'h07, 16'h0020, 0);
		push(CH7, 14'h0100);
		wr(5'h07, 16'ha008, 1);
		push(CH7, 14'h0200);
		push(SUP, 14'h0100);
		rc("filtered", 5'h16, 1, 16'h8110);
		rc("supply raw", 5'h1c, 1, 16'h8100);
	endtask : t_filt

	task automatic t_pwm();
		wr(5'h08, 16'hc800, 1);
		pwmChk("duty", 512 * STEP, (16'h0110 - 16'h0010) * STEP);
		wr(5'h08, 16'h40f0, 1);
		pwmChk("sat high", 400, 400);
		wr(5'h08, 16'h0060, 0);
		pwmChk("inverted", 400, 0);
		wr(5'h08, 16'h607f, 1);
		pwmChk("below inv", 400, 400);
		wr(5'h08, 16'h0020, 0);
		pwmChk("disabled", 400, 0);
	endtask : t_pwm

	// A result offered during a read waits until the master ends the read
	task automatic t_freeze();
		logic [1:0] nk;
		logic       na;
		logic [7:0] g;
		head(5'h0a, nk);
		i_i2c_host.sendStart();
		i_i2c_host.putByte({DEV, 1'b1}, na);
		sampleValid = 1'b1;
		sample = {4'h1, 14'h0042};
		repeat (100) @(negedge core_clk);
		chk("ready in read", 16'h0000, {15'h0000, sampleReady});
		i_i2c_host.getByte(1'b1, g);
		i_i2c_host.sendStop();
		chk("upper slot0", 16'h006a, {8'h00, g});
		push(4'h1, 14'h0042);
		rc("status late", 5'h00, 0, 16'h0002);
	endtask : t_freeze

	initial begin
		repeat (16) @(negedge core_clk);
		srst = 1'b0;
		repeat (4) @(negedge core_clk);
		t_regs();
		t_temp();
		t_volt();
		t_filt();
		t_pwm();
		t_freeze();
		summarize();
	end

	// Cuts a hang at 3 ms, only about a sixth past the expected run length of about 2.6 ms
	initial begin
		#3_000_000;
		nFail++;
		$display("BAD watchdog exp done got hang");
		summarize();
	end
endmodule : tb
